/* hdl/rtis_core.sv */
// rtc interrupt control, event flags and serial slave port
`timescale 1ns/100ps
`include "rtis_cfg.svh"
module rtis_core #(parameter logic [15:0] WD_TICKS = `RTIS_WD_TICKS)
(
   // clock and power-on reset
   input wire logic clk,
   input wire logic rst_n,
   // serial pins
   input wire logic ce,
   input wire logic sck,
   input wire logic mosi,
   output logic miso_o,
   output logic miso_oe,
   // time base pulses, one clk wide
   input wire logic [14:0] rate_tick,
   input wire logic line_tick,
   input wire logic wd_tick,
   // event sources
   input wire logic alarm_match,
   input wire logic test_mode,
   input wire logic power_fail,
   input wire logic vsys_rise,
   // open-drain outputs
   output logic irq_o,
   output logic irq_oe,
   output logic host_reset_o,
   output logic host_reset_oe,
   // power and clock control
   output logic supply_enable_output,
   output logic clk_out_en,
   output logic line_prescale_en,
   output logic [7:0] clock_config_o
);
   // reset release pipe
   logic [1:0] rst_pipe_ff;
   logic rst_s_n;
   // synchronised pins
   logic [4:0] pin_s;
   logic ce_s, sck_s, mosi_s, pf_s, vs_s;
   // serial engine state
   rtis_pkg::rtis_sp_t st_ff, nxt_st;
   logic pol_ff, nxt_pol; // idle clock level
   logic sck_d_ff, nxt_sck_d; // last clock sample
   logic [2:0] bit_ff, nxt_bit; // bit in byte
   logic [7:0] rx_ff, nxt_rx; // input shifter
   logic [7:0] tx_ff, nxt_tx; // output shifter
   logic out_ff, nxt_out; // data pin level
   logic oe_ff, nxt_oe; // data pin drive
   logic wr_ff, nxt_wr; // write transfer
   rtis_pkg::rtis_addr_t addr_ff, nxt_addr;
   // serial strobes to the register group
   logic ce_act, lead, trail, byte_done;
   logic [7:0] rx_new;
   logic wr_stb, rd_stb;
   rtis_pkg::rtis_addr_t rd_addr;
   // register group state
   logic [7:0] cfg_ff, nxt_cfg; // clock_config
   logic [7:0] ctl_ff, nxt_ctl; // irq_enable_control
   logic [7:0] stat_ff, nxt_stat; // event_flags
   logic irq_ff, nxt_irq; // interrupt pending
   logic arm_ff, nxt_arm; // power sense armed
   logic [15:0] wd_cnt_ff, nxt_wd_cnt;
   logic wd_rst_ff, nxt_wd_rst; // watchdog reset hold
   logic ce_d_ff, pf_d_ff, al_d_ff, vs_d_ff;
   // events
   logic per_ev, alarm_ev, ps_ev, any_ev, wd_fire, ce_tog, stat_rd;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_s_n);

   // address step, wraps inside clock or ram space
   function automatic rtis_pkg::rtis_addr_t addr_inc
      (input rtis_pkg::rtis_addr_t a);
      addr_inc = {a[5], a[4:0] + 5'h01};
   endfunction : addr_inc

   // register read mux, unmapped reads give zero
   function automatic logic [7:0] reg_read(input rtis_pkg::rtis_addr_t a,
      input logic [7:0] cfg, input logic [7:0] ctl, input logic [7:0] st);
      case (a)
         `RTIS_CLK_CFG_ADDR: reg_read = cfg;
         `RTIS_IRQ_CTL_ADDR: reg_read = ctl;
         `RTIS_STAT_ADDR: reg_read = st;
         default: reg_read = 8'h00;
      endcase
   endfunction : reg_read

   // periodic tick by code and time base
   function automatic logic sel_tick(input logic [3:0] code,
      input logic line_base, input logic [14:0] rt, input logic lt);
      if (code == 4'h0)
         sel_tick = 1'b0;
      else if (!line_base)
         sel_tick = rt[code - 4'h1];
      else if (code == `RTIS_PER_LINE_CODE)
         sel_tick = lt;
      else if (code >= `RTIS_PER_LINE_MIN)
         sel_tick = rt[code - 4'h1];
      else
         sel_tick = 1'b0;
   endfunction : sel_tick

   // power-on reset released through two flops
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rst_pipe_ff <= 2'b00;
      else
         rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
   end
   assign rst_s_n = rst_pipe_ff[1];

   // serial, power-fail and supply-rise pins pass two flops first
   rtis_sync #(.W(5)) u_sync
   (
      .clk(clk),
      .rst_n(rst_s_n),
      .d({ce, sck, mosi, power_fail, vsys_rise}),
      .q(pin_s)
   );
   assign {ce_s, sck_s, mosi_s, pf_s, vs_s} = pin_s;

   // serial port off in power-down
   assign ce_act = ce_s & ~ctl_ff[`RTIS_CTL_PDOWN];
   // leaving idle shifts out, returning latches in
   assign lead = (st_ff != rtis_pkg::SP_IDLE) && (sck_s != pol_ff)
      && (sck_d_ff == pol_ff);
   assign trail = (st_ff != rtis_pkg::SP_IDLE) && (sck_s == pol_ff)
      && (sck_d_ff != pol_ff);
   assign byte_done = trail && (bit_ff == 3'h7);
   assign rx_new = {rx_ff[6:0], mosi_s};

   // serial engine next state
   always_comb
   begin
      nxt_st = st_ff;
      nxt_pol = pol_ff;
      nxt_sck_d = sck_s;
      nxt_bit = bit_ff;
      nxt_rx = rx_ff;
      nxt_tx = tx_ff;
      nxt_out = out_ff;
      nxt_oe = oe_ff;
      nxt_wr = wr_ff;
      nxt_addr = addr_ff;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      rd_addr = addr_ff;
      if (!ce_act)
      begin
         // held in reset, pin floats
         nxt_st = rtis_pkg::SP_IDLE;
         nxt_oe = 1'b0;
         nxt_bit = 3'h0;
      end
      else if (st_ff == rtis_pkg::SP_IDLE)
      begin
         // select just rose: take idle level
         nxt_st = rtis_pkg::SP_ADDR;
         nxt_pol = sck_s;
         nxt_bit = 3'h0;
      end
      else
      begin
         if (lead)
         begin
            // next bit out, msb first
            nxt_out = tx_ff[7];
            nxt_tx = {tx_ff[6:0], 1'b0};
         end
         if (trail)
         begin
            nxt_rx = rx_new;
            nxt_bit = bit_ff + 3'h1;
         end
         if (byte_done && (st_ff == rtis_pkg::SP_ADDR))
         begin
            // control byte: direction and address
            nxt_st = rtis_pkg::SP_DATA;
            nxt_wr = rx_new[`RTIS_AC_WRITE];
            nxt_addr = rx_new[5:0];
            if (!rx_new[`RTIS_AC_WRITE])
            begin
               rd_stb = 1'b1;
               rd_addr = rx_new[5:0];
               nxt_addr = addr_inc(rx_new[5:0]);
               nxt_oe = 1'b1;
            end
         end
         else if (byte_done && wr_ff)
         begin
            // data byte stored, pin stays off
            wr_stb = 1'b1;
            nxt_addr = addr_inc(addr_ff);
         end
         else if (byte_done)
         begin
            // next read byte
            rd_stb = 1'b1;
            nxt_addr = addr_inc(addr_ff);
         end
         if (rd_stb)
            nxt_tx = reg_read(rd_addr, cfg_ff, ctl_ff, stat_ff);
      end
   end

   // serial engine registers
   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         st_ff <= rtis_pkg::SP_IDLE;
         pol_ff <= 1'b0;
         sck_d_ff <= 1'b0;
         bit_ff <= 3'h0;
         rx_ff <= 8'h00;
         tx_ff <= 8'h00;
         out_ff <= 1'b0;
         oe_ff <= 1'b0;
         wr_ff <= 1'b0;
         addr_ff <= 6'h00;
      end
      else
      begin
         st_ff <= nxt_st;
         pol_ff <= nxt_pol;
         sck_d_ff <= nxt_sck_d;
         bit_ff <= nxt_bit;
         rx_ff <= nxt_rx;
         tx_ff <= nxt_tx;
         out_ff <= nxt_out;
         oe_ff <= nxt_oe;
         wr_ff <= nxt_wr;
         addr_ff <= nxt_addr;
      end
   end

   // event detection
   assign stat_rd = rd_stb && (rd_addr == `RTIS_STAT_ADDR);
   assign per_ev = sel_tick(ctl_ff[3:0], cfg_ff[`RTIS_CFG_LINE],
      rate_tick, line_tick);
   assign alarm_ev = ctl_ff[`RTIS_CTL_ALARM] & alarm_match
      & ~al_d_ff;
   assign ps_ev = ctl_ff[`RTIS_CTL_PSENSE] & arm_ff & pf_s
      & ~pf_d_ff;
   assign any_ev = per_ev | alarm_ev | ps_ev;
   assign ce_tog = ce_s ^ ce_d_ff;
   assign wd_fire = ctl_ff[`RTIS_CTL_WDOG] & wd_tick & ~ce_tog
      & (wd_cnt_ff == WD_TICKS - 16'h0001);

   // register group next state
   always_comb
   begin
      nxt_cfg = cfg_ff;
      nxt_ctl = ctl_ff;
      nxt_arm = ps_ev ? 1'b0 : arm_ff;
      if (wr_stb && (addr_ff == `RTIS_CLK_CFG_ADDR))
         nxt_cfg = rx_new;
      if (wr_stb && (addr_ff == `RTIS_IRQ_CTL_ADDR))
      begin
         nxt_ctl = rx_new;
         // re-armed only by a 0 to 1 write
         if (rx_new[`RTIS_CTL_PSENSE] && !ctl_ff[`RTIS_CTL_PSENSE])
            nxt_arm = 1'b1;
      end
      // interrupt or supply return ends power-down
      if (irq_ff || (vs_s && !vs_d_ff))
         nxt_ctl[`RTIS_CTL_PDOWN] = 1'b0;
      // read clears all but the power sense flag and the test flag, which follows test_mode; new events win
      nxt_stat = stat_rd ? (stat_ff & `RTIS_STAT_KEEP) : stat_ff;
      nxt_stat[`RTIS_ST_PER] = nxt_stat[`RTIS_ST_PER] | per_ev;
      nxt_stat[`RTIS_ST_ALARM] = nxt_stat[`RTIS_ST_ALARM] | alarm_ev;
      nxt_stat[`RTIS_ST_PSENSE] = nxt_stat[`RTIS_ST_PSENSE] | ps_ev;
      nxt_stat[`RTIS_ST_ANY] = nxt_stat[`RTIS_ST_ANY] | any_ev;
      nxt_stat[`RTIS_ST_WDOG] = nxt_stat[`RTIS_ST_WDOG] | wd_fire;
      nxt_stat[`RTIS_ST_TEST] = test_mode;
      nxt_stat[7] = 1'b0;
      nxt_irq = any_ev | (irq_ff & ~stat_rd);
      // watchdog restarts on each select toggle
      if (!ctl_ff[`RTIS_CTL_WDOG] || ce_tog || wd_fire)
         nxt_wd_cnt = 16'h0000;
      else if (wd_tick)
         nxt_wd_cnt = wd_cnt_ff + 16'h0001;
      else
         nxt_wd_cnt = wd_cnt_ff;
      nxt_wd_rst = wd_fire | (wd_rst_ff & ~ce_tog);
   end

   // register group registers, power-on values
   always_ff @(posedge clk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         cfg_ff <= `RTIS_CFG_RST;
         ctl_ff <= `RTIS_CTL_RST;
         stat_ff <= `RTIS_STAT_RST;
         irq_ff <= 1'b0;
         arm_ff <= 1'b0;
         wd_cnt_ff <= 16'h0000;
         wd_rst_ff <= 1'b0;
         ce_d_ff <= 1'b0;
         pf_d_ff <= 1'b0;
         al_d_ff <= 1'b0;
         vs_d_ff <= 1'b0;
      end
      else
      begin
         cfg_ff <= nxt_cfg;
         ctl_ff <= nxt_ctl;
         stat_ff <= nxt_stat;
         irq_ff <= nxt_irq;
         arm_ff <= nxt_arm;
         wd_cnt_ff <= nxt_wd_cnt;
         wd_rst_ff <= nxt_wd_rst;
         ce_d_ff <= ce_s;
         pf_d_ff <= pf_s;
         al_d_ff <= alarm_match;
         vs_d_ff <= vs_s;
      end
   end

   // pin drive
   assign miso_o = out_ff;
   assign miso_oe = oe_ff & ce_act;
   assign irq_o = 1'b0;
   assign irq_oe = irq_ff;
   assign host_reset_o = 1'b0;
   assign host_reset_oe = ctl_ff[`RTIS_CTL_PDOWN] | wd_rst_ff;
   assign supply_enable_output = ~ctl_ff[`RTIS_CTL_PDOWN];
   assign clk_out_en = ~ctl_ff[`RTIS_CTL_PDOWN];
   assign line_prescale_en = ~ctl_ff[`RTIS_CTL_PSENSE];
   assign clock_config_o = cfg_ff;

   // checks
   sequence s_wd_expire;
      wd_fire;
   endsequence
   sequence s_rd_status;
      stat_rd && !per_ev;
   endsequence
   a_wd_reset_out: assert property (s_wd_expire |=> host_reset_oe
      && stat_ff[`RTIS_ST_WDOG])
      else $error("watchdog expiry without reset");
   a_stat_rd_clear: assert property (s_rd_status |=>
      !stat_ff[`RTIS_ST_PER])
      else $error("periodic flag not cleared by read");
   a_ps_sticky: assert property (stat_rd && stat_ff[`RTIS_ST_PSENSE]
      |=> stat_ff[`RTIS_ST_PSENSE])
      else $error("power sense flag lost on read");
   a_per_irq: assert property (per_ev |=> irq_oe
      && stat_ff[`RTIS_ST_PER] && stat_ff[`RTIS_ST_ANY])
      else $error("periodic event missed");
   a_alarm_flag: assert property (alarm_ev |=> stat_ff[`RTIS_ST_ALARM]
      && irq_oe)
      else $error("alarm event missed");
   a_ps_flag: assert property (ps_ev |=> stat_ff[`RTIS_ST_PSENSE]
      && stat_ff[`RTIS_ST_ANY] && !arm_ff)
      else $error("power sense event missed");
   a_pd_outputs: assert property (ctl_ff[`RTIS_CTL_PDOWN] |->
      !supply_enable_output && host_reset_oe && !miso_oe)
      else $error("power-down outputs wrong");
   a_pol_capture: assert property ($rose(st_ff == rtis_pkg::SP_ADDR)
      |-> pol_ff == $past(sck_s))
      else $error("idle polarity not captured");
   a_write_hiz: assert property (wr_ff && st_ff == rtis_pkg::SP_DATA
      |-> !miso_oe)
      else $error("data pin driven in write");
endmodule : rtis_core

/* hdl/rtis_cfg.svh */
// offsets, bit positions, reset values and counts of the rtc irq block
`ifndef RTIS_CFG_SVH
`define RTIS_CFG_SVH
// register addresses: {clock/ram select, a4..a0}
`define RTIS_STAT_ADDR 6'h30
`define RTIS_CLK_CFG_ADDR 6'h31
`define RTIS_IRQ_CTL_ADDR 6'h32
// irq_enable_control bits
`define RTIS_CTL_WDOG 7
`define RTIS_CTL_PDOWN 6
`define RTIS_CTL_PSENSE 5
`define RTIS_CTL_ALARM 4
// clock_config bit that picks the line time base
`define RTIS_CFG_LINE 6
// event_flags bits
`define RTIS_ST_WDOG 6
`define RTIS_ST_TEST 5
`define RTIS_ST_FIRST 4
`define RTIS_ST_ANY 3
`define RTIS_ST_PSENSE 2
`define RTIS_ST_ALARM 1
`define RTIS_ST_PER 0
// reset values and the mask kept over a status read
`define RTIS_CTL_RST 8'h00
`define RTIS_CFG_RST 8'h00
`define RTIS_STAT_RST 8'h10
`define RTIS_STAT_KEEP 8'h04
// periodic codes
`define RTIS_PER_LINE_CODE 4'h6
`define RTIS_PER_LINE_MIN 4'hB
// control byte: write select bit
`define RTIS_AC_WRITE 7
// watchdog timeout in time-base ticks
`define RTIS_WD_TICKS 16'h0010
`endif

/* hdl/rtis_pkg.sv */
// types of the rtc irq block
package rtis_pkg;
   // serial engine states, gray along idle -> addr -> data
   typedef enum logic [1:0]
   {
      SP_IDLE = 2'b00,
      SP_ADDR = 2'b01,
      SP_DATA = 2'b11
   } rtis_sp_t;
   // register address: clock/ram select and five address bits
   typedef logic [5:0] rtis_addr_t;
endpackage : rtis_pkg

/* hdl/rtis_sync.sv */
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module rtis_sync #(parameter int W = 1)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // asynchronous in, synchronous out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   genvar i;
   // one independent two-stage chain per bit
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         logic meta_ff; // first stage, read only by second
         logic sync_ff; // second stage
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta_ff <= 1'b0;
               sync_ff <= 1'b0;
            end
            else
            begin
               meta_ff <= d[i];
               sync_ff <= meta_ff;
            end
         end
         assign q[i] = sync_ff;
      end
   endgenerate
endmodule : rtis_sync

/* verification/rtis_host_model.sv */
// host serial master model driving select, clock and data pins
`timescale 1ns/100ps
module rtis_host_model
(
   // pacing clock
   input wire logic clk,
   // device data out and its drive enable
   input wire logic miso_o,
   input wire logic miso_oe,
   // pins driven by the host
   output logic ce,
   output logic sck,
   output logic mosi
);
   logic last = 1'b0; // last level seen on the data line
   logic float_bad = 1'b0; // data out driven when it must float
   logic line; // level on the data line
   // pins idle at time zero
   initial
   begin
      ce = 1'b0;
      sck = 1'b0;
      mosi = 1'b0;
   end
   // wait n clocks, then step just past the edge
   task automatic clks(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : clks
   // one byte msb first, one sck cycle a bit
   task automatic shift(input logic p, input logic [7:0] tx,
      input logic drive_ok, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         clks(10);
         sck = ~p; // leave idle
         // data moves mid half-cycle, so only the return edge can take it
         clks(5);
         mosi = tx[i];
         clks(5);
         sck = p; // back to idle, bit taken
         // released line shows the inverse, never a stale bit
         line = miso_oe ? miso_o : ~last;
         last = line;
         rx[i] = line;
         if (miso_oe && !drive_ok)
            float_bad = 1'b1;
      end
   endtask : shift
   // select, control byte, one data byte, deselect
   task automatic xfer(input logic p, input logic [7:0] c,
      input logic [7:0] d, output logic [7:0] rx);
      sck = p; // idle level set before select
      clks(2);
      ce = 1'b1;
      clks(4);
      shift(p, c, 1'b0, rx);
      shift(p, d, ~c[7], rx);
      clks(10);
      ce = 1'b0;
      clks(6);
      if (miso_oe)
         float_bad = 1'b1;
   endtask : xfer
   // select pulse with no clocks, restarts the watchdog
   task automatic toggle();
      ce = 1'b1;
      clks(4);
      ce = 1'b0;
      clks(4);
   endtask : toggle
endmodule : rtis_host_model

/* verification/tb_rtis_core.sv */
// self-checking bench of the rtc irq block and its serial port
`timescale 1ns/100ps
module tb_rtis_core;
   localparam logic [15:0] WD = 16'h0004; // shortened watchdog span
   // clock, reset and pins
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce, sck, mosi, miso_o, miso_oe;
   logic [14:0] rate_tick = 15'h0000;
   logic line_tick = 1'b0;
   logic wd_tick = 1'b0;
   logic alarm_match = 1'b0;
   logic test_mode = 1'b0;
   logic power_fail = 1'b0;
   logic vsys_rise = 1'b0;
   logic irq_o, irq_oe, host_reset_o, host_reset_oe;
   logic supply_enable_output, clk_out_en, line_prescale_en;
   logic [7:0] clock_config_o;
   logic pol = 1'b0; // sck idle level, flips each transfer
   logic [7:0] rx; // byte returned by the host model
   logic [14:0] rt; // periodic ticks of one step
   logic lt; // line tick of one step
   logic ex; // interrupt expected
   int num_errors = 0;
   int total_checks = 0;
   // device under test, shortened watchdog
   rtis_core #(.WD_TICKS(WD)) i_dut
   (
      .clk(clk), .rst_n(rst_n), .ce(ce), .sck(sck), .mosi(mosi),
      .miso_o(miso_o), .miso_oe(miso_oe), .rate_tick(rate_tick),
      .line_tick(line_tick), .wd_tick(wd_tick),
      .alarm_match(alarm_match), .test_mode(test_mode),
      .power_fail(power_fail), .vsys_rise(vsys_rise), .irq_o(irq_o),
      .irq_oe(irq_oe), .host_reset_o(host_reset_o),
      .host_reset_oe(host_reset_oe),
      .supply_enable_output(supply_enable_output),
      .clk_out_en(clk_out_en), .line_prescale_en(line_prescale_en),
      .clock_config_o(clock_config_o)
   );
   // host master on the serial pins
   rtis_host_model i_host
   (
      .clk(clk), .miso_o(miso_o), .miso_oe(miso_oe), .ce(ce),
      .sck(sck), .mosi(mosi)
   );
   // 125 MHz clock
   initial
   begin
      forever #4 clk = ~clk;
   end
   // compare and count
   task automatic chk(input string nm, input logic [7:0] seen,
      input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // wait n clocks, then step just past the edge
   task automatic clks(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : clks
   // register write, data out must float throughout
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      i_host.xfer(pol, {2'b10, a}, d, rx);
      pol = ~pol;
      chk("float", {7'h0, i_host.float_bad}, 8'h00);
   endtask : wr
   // register read against expected byte
   task automatic rd(input logic [5:0] a, input logic [7:0] e,
      input string nm);
      i_host.xfer(pol, {2'b00, a}, 8'h00, rx);
      pol = ~pol;
      chk(nm, rx, e);
   endtask : rd
   // one-clock pulse on the time base inputs
   task automatic pulse(input logic [14:0] r, input logic l,
      input logic w);
      rate_tick = r;
      line_tick = l;
      wd_tick = w;
      clks(1);
      rate_tick = 15'h0000;
      line_tick = 1'b0;
      wd_tick = 1'b0;
   endtask : pulse
   // print counts and verdict, end the run
   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   // hang guard
   initial
   begin
      #600000;
      num_errors++;
      give_verdict();
   end
   // main sequence
   initial
   begin
      clks(5);
      rst_n = 1'b1;
      clks(8);
      rd(6'h30, 8'h10, "status por");
      rd(6'h30, 8'h00, "status clr");
      rd(6'h32, 8'h00, "ctl por");
      wr(6'h31, 8'hA5);
      chk("cfg pins", clock_config_o, 8'hA5);
      rd(6'h31, 8'hA5, "cfg read");
      wr(6'h3E, 8'hFF);
      rd(6'h3E, 8'h00, "unmapped");
      // every periodic code on both time bases
      for (int b = 0; b < 2; b++)
         for (int c = 0; c < 16; c++)
         begin
            if (c == 0)
               wr(6'h31, b ? 8'h40 : 8'h00);
            wr(6'h32, 8'(c));
            lt = (b == 1 && c == 6);
            rt = (c == 0) ? 15'h7FFF : (lt ? 15'h0 : 15'h1 << (c - 1));
            ex = c != 0 && (b == 0 || lt || c >= 11);
            pulse(rt, lt, 1'b0);
            clks(3);
            chk("irq per", {7'h0, irq_oe}, {7'h0, ex});
            if (ex)
            begin
               rd(6'h30, 8'h09, "st per");
               chk("irq rel", {7'h0, irq_oe}, 8'h00);
            end
         end
      // alarm, enabled then disabled
      wr(6'h32, 8'h10);
      alarm_match = 1'b1;
      clks(3);
      chk("irq alarm", {7'h0, irq_oe}, 8'h01);
      rd(6'h30, 8'h0A, "st alarm");
      alarm_match = 1'b0;
      wr(6'h32, 8'h00);
      alarm_match = 1'b1;
      clks(3);
      chk("alarm off", {7'h0, irq_oe}, 8'h00);
      alarm_match = 1'b0;
      test_mode = 1'b1;
      rd(6'h30, 8'h20, "st test");
      test_mode = 1'b0;
      // watchdog: restart on toggle, then time out
      wr(6'h32, 8'h80);
      repeat (WD - 1) pulse(15'h0, 1'b0, 1'b1);
      i_host.toggle();
      repeat (WD - 1) pulse(15'h0, 1'b0, 1'b1);
      clks(3);
      chk("wd early", {7'h0, host_reset_oe}, 8'h00);
      pulse(15'h0, 1'b0, 1'b1);
      clks(3);
      chk("wd reset", {7'h0, host_reset_oe}, 8'h01);
      rd(6'h30, 8'h40, "st wd");
      chk("wd rel", {7'h0, host_reset_oe}, 8'h00);
      wr(6'h32, 8'h00);
      // power-down, ended by supply rise and then by interrupt
      wr(6'h32, 8'h40);
      chk("pd pins", {5'h0, supply_enable_output, clk_out_en,
         host_reset_oe}, 8'h01);
      wr(6'h31, 8'h5A);
      chk("pd serial", clock_config_o, 8'h40);
      vsys_rise = 1'b1;
      clks(5);
      chk("pd vsys", {5'h0, supply_enable_output, clk_out_en,
         host_reset_oe}, 8'h06);
      vsys_rise = 1'b0;
      // line base still selected: code 11 is one that runs there
      wr(6'h32, 8'h4B);
      chk("pd again", {7'h0, supply_enable_output}, 8'h00);
      pulse(15'h0400, 1'b0, 1'b0);
      clks(3);
      chk("pd irq", {7'h0, supply_enable_output}, 8'h01);
      chk("od levels", {6'h0, irq_o, host_reset_o}, 8'h00);
      rd(6'h30, 8'h09, "st pd");
      // power sense on the crystal base
      wr(6'h31, 8'h00);
      wr(6'h32, 8'h20);
      chk("prescale", {7'h0, line_prescale_en}, 8'h00);
      power_fail = 1'b1;
      clks(5);
      chk("irq ps", {7'h0, irq_oe}, 8'h01);
      rd(6'h30, 8'h0C, "st ps");
      power_fail = 1'b0;
      rd(6'h30, 8'h04, "st ps kept");
      power_fail = 1'b1;
      clks(5);
      chk("ps unarmed", {7'h0, irq_oe}, 8'h00);
      power_fail = 1'b0;
      wr(6'h32, 8'h00);
      wr(6'h32, 8'h20);
      power_fail = 1'b1;
      clks(5);
      chk("ps rearm", {7'h0, irq_oe}, 8'h01);
      give_verdict();
   end
endmodule : tb_rtis_core
